// file: hdl/tcx_edge_det.v
// Level change detector for one synchronous input
`default_nettype none

module tcx_edge_det #(
  parameter RESET_LEVEL = 1'b0
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire level_in,
  output wire rise_out,
  output wire fall_out
);

  reg prev_reg;

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_reg <= RESET_LEVEL;
    end else begin
      prev_reg <= level_in;
    end
  end

  assign rise_out = level_in & ~prev_reg;
  assign fall_out = ~level_in & prev_reg;

endmodule

`default_nettype wire

// file: hdl/tcx_map.vh
// Register locations, field positions, reset values and prescaler counts for the timer block
`ifndef TCX_MAP_VH
`define TCX_MAP_VH

`define TCX_ADDR_W 4
`define TCX_ADDR_CTRL_A 4'h0
`define TCX_ADDR_CTRL_B 4'h1
`define TCX_ADDR_FLAGS 4'h2
`define TCX_ADDR_MASK 4'h3
`define TCX_ADDR_CNT_LO 4'h4
`define TCX_ADDR_CNT_HI 4'h5
`define TCX_ADDR_CAP_LO 4'h6
`define TCX_ADDR_CAP_HI 4'h7
`define TCX_ADDR_CMPA_LO 4'h8
`define TCX_ADDR_CMPA_HI 4'h9
`define TCX_ADDR_CMPB_LO 4'ha
`define TCX_ADDR_CMPB_HI 4'hb

`define TCX_A_WAVE_LO 1:0
`define TCX_A_CAP_SRC 2
`define TCX_B_CLK_SEL 2:0
`define TCX_B_WAVE_HI 4:3
`define TCX_B_EDGE_SEL 6
`define TCX_FLAG_OVF 0
`define TCX_FLAG_CAP 5

`define TCX_RST_CTRL_A 8'h00
`define TCX_RST_CTRL_B 8'h00
`define TCX_RST_MASK 8'h00
`define TCX_RST_COUNT 16'h0000
`define TCX_RST_WORD 16'h0000

`define TCX_PRE_W 10
`define TCX_PRE_DIV8 10'h007
`define TCX_PRE_DIV64 10'h03f
`define TCX_PRE_DIV256 10'h0ff
`define TCX_PRE_DIV1024 10'h3ff

`define TCX_MIN_COUNT 16'h0000
`define TCX_MAX_COUNT 16'hffff
`define TCX_TOP_8BIT 16'h00ff
`define TCX_TOP_9BIT 16'h01ff
`define TCX_TOP_10BIT 16'h03ff

`endif

// file: hdl/tcx_timer16.v
// Sixteen-bit timer with input capture behind an 8-bit register port
//
// Behaviour
// [RULE1] Counter seen as upper and lower byte locations
// [RULE2] Upper-byte counter access goes to shared latch
// [RULE3] Lower-byte counter read latches upper byte
// [RULE4] Lower-byte counter write loads all sixteen bits
// [RULE5] Software blocks interrupts around two-byte accesses
// [RULE6] Shared latch holds value between writes
// [RULE7] Three-bit clock select; zero halts counter
// [RULE8] Up/down counter steps or clears per tick
// [RULE9] Internal top and bottom indications
// [RULE10] Processor write beats clear or count
// [RULE11] Counter accessible even while halted
// [RULE12] Four-bit waveform mode split over two controls
// [RULE13] Overflow flag set per mode; raises interrupt
// [RULE14] Capture on selected edge of pin or comparator
// [RULE15] Capture copies count and sets flag together
// [RULE16] Enabled capture flag interrupts; clears when serviced
// [RULE17] Writing one clears capture flag
// [RULE18] Capture low read latches its upper byte
// [RULE19] Capture writable only in capture-top modes
// [RULE20] Software writes capture upper byte first
// [RULE21] Software writes high first, reads low first
// [RULE22] Compare value reads bypass the shared latch
// [RULE23] Count range is 0x0000 to 0xffff
// [RULE24] One bit selects rising or falling capture edge
`default_nettype none
`include "tcx_map.vh"

module tcx_timer16 (
  input wire sys_clk_in,
  input wire rst_in,
  input wire [`TCX_ADDR_W-1:0] bus_addr_in,
  input wire [7:0] bus_wdata_in,
  input wire bus_wr_in,
  input wire bus_rd_in,
  output wire [7:0] bus_rdata_out,
  input wire ext_tick_in,
  input wire capture_pin_in,
  input wire comparator_output_in,
  input wire overflow_irq_ack_in,
  input wire capture_irq_ack_in,
  output wire overflow_irq_out,
  output wire capture_irq_out
);

  reg [7:0] control_reg_a_reg;
  reg [7:0] control_reg_b_reg;
  reg [7:0] mask_reg;
  reg overflow_flag_reg;
  reg capture_flag_reg;
  reg [15:0] timer_count_reg;
  reg count_up_reg;
  reg [15:0] capture_value_reg;
  reg [15:0] compare_a_reg;
  reg [15:0] compare_b_reg;
  reg [7:0] temp_byte_reg;
  reg [7:0] rdata_reg;
  reg overflow_irq_reg;
  reg capture_irq_reg;
  reg [`TCX_PRE_W-1:0] prescale_reg;
  reg [15:0] timer_count_next;
  reg count_up_next;
  reg [15:0] top_value;
  reg [15:0] fixed_top;
  reg dual_slope;
  reg ovf_at_top;
  reg ovf_at_bottom;
  reg capture_is_top;
  reg timer_tick;
  reg [7:0] rdata_next;
  wire [2:0] clock_source_select;
  wire [3:0] waveform_mode_select;
  wire wr_cnt_lo;
  wire rd_cnt_lo;
  wire wr_cap_lo;
  wire rd_cap_lo;
  wire wr_any_hi;
  wire at_top;
  wire at_bottom;
  wire at_max;
  wire overflow_event;
  wire capture_source;
  wire cap_rise;
  wire cap_fall;
  wire ext_rise;
  wire ext_fall;
  wire capture_event;

  assign clock_source_select = control_reg_b_reg[`TCX_B_CLK_SEL];
  assign waveform_mode_select = {control_reg_b_reg[`TCX_B_WAVE_HI], control_reg_a_reg[`TCX_A_WAVE_LO]}; // [RULE12]

  assign wr_cnt_lo = bus_wr_in & (bus_addr_in == `TCX_ADDR_CNT_LO);
  assign rd_cnt_lo = bus_rd_in & (bus_addr_in == `TCX_ADDR_CNT_LO);
  assign wr_cap_lo = bus_wr_in & (bus_addr_in == `TCX_ADDR_CAP_LO);
  assign rd_cap_lo = bus_rd_in & (bus_addr_in == `TCX_ADDR_CAP_LO);
  assign wr_any_hi = bus_wr_in & ((bus_addr_in == `TCX_ADDR_CNT_HI) | (bus_addr_in == `TCX_ADDR_CAP_HI) |
                     (bus_addr_in == `TCX_ADDR_CMPA_HI) | (bus_addr_in == `TCX_ADDR_CMPB_HI));

  // Edge detectors for the external tick and the capture source
  tcx_edge_det #(.RESET_LEVEL(1'b0)) u_ext_edge (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .level_in(ext_tick_in),
    .rise_out(ext_rise),
    .fall_out(ext_fall)
  );

  assign capture_source = control_reg_a_reg[`TCX_A_CAP_SRC] ? comparator_output_in : capture_pin_in; // [RULE14]

  tcx_edge_det #(.RESET_LEVEL(1'b0)) u_cap_edge (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .level_in(capture_source),
    .rise_out(cap_rise),
    .fall_out(cap_fall)
  );

  // Capture input is idle while the capture register defines top
  assign capture_event = (control_reg_b_reg[`TCX_B_EDGE_SEL] ? cap_rise : cap_fall) & ~capture_is_top; // [RULE24]

  // Free-running prescaler
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prescale_reg <= {`TCX_PRE_W{1'b0}};
    end else begin
      prescale_reg <= prescale_reg + 1'b1;
    end
  end

  // Timer tick selection
  always @* begin
    case (clock_source_select)
      3'h0: timer_tick = 1'b0; // [RULE7]
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = ((prescale_reg & `TCX_PRE_DIV8) == `TCX_PRE_DIV8);
      3'h3: timer_tick = ((prescale_reg & `TCX_PRE_DIV64) == `TCX_PRE_DIV64);
      3'h4: timer_tick = ((prescale_reg & `TCX_PRE_DIV256) == `TCX_PRE_DIV256);
      3'h5: timer_tick = (prescale_reg == `TCX_PRE_DIV1024);
      3'h6: timer_tick = ext_fall;
      3'h7: timer_tick = ext_rise;
      default: timer_tick = 1'b0;
    endcase
  end

  // Waveform mode decode: top value, slope and overflow point
  always @* begin
    fixed_top = (waveform_mode_select[1:0] == 2'h1) ? `TCX_TOP_8BIT :
                (waveform_mode_select[1:0] == 2'h2) ? `TCX_TOP_9BIT : `TCX_TOP_10BIT;
    top_value = `TCX_MAX_COUNT;
    dual_slope = 1'b0;
    ovf_at_top = 1'b0;
    capture_is_top = 1'b0;
    case (waveform_mode_select)
      4'h1, 4'h2, 4'h3: begin
        top_value = fixed_top;
        dual_slope = 1'b1;
      end
      4'h4: top_value = compare_a_reg;
      4'h5, 4'h6, 4'h7: begin
        top_value = fixed_top;
        ovf_at_top = 1'b1;
      end
      4'h8, 4'ha: begin
        top_value = capture_value_reg;
        dual_slope = 1'b1;
        capture_is_top = 1'b1;
      end
      4'h9, 4'hb: begin
        top_value = compare_a_reg;
        dual_slope = 1'b1;
      end
      4'hc: begin
        top_value = capture_value_reg;
        capture_is_top = 1'b1;
      end
      4'he: begin
        top_value = capture_value_reg;
        ovf_at_top = 1'b1;
        capture_is_top = 1'b1;
      end
      4'hf: begin
        top_value = compare_a_reg;
        ovf_at_top = 1'b1;
      end
      default: top_value = `TCX_MAX_COUNT;
    endcase
    ovf_at_bottom = dual_slope;
  end

  assign at_top = (timer_count_reg == top_value); // [RULE9]
  assign at_bottom = (timer_count_reg == `TCX_MIN_COUNT); // [RULE9]
  assign at_max = (timer_count_reg == `TCX_MAX_COUNT); // [RULE23]

  // Overflow point of each mode; a lower-byte counter write suppresses it
  assign overflow_event = timer_tick & ~wr_cnt_lo & (ovf_at_bottom ? (at_bottom & ~count_up_reg) :
                          ovf_at_top ? at_top : at_max); // [RULE13]

  // Counter next value
  always @* begin
    timer_count_next = timer_count_reg;
    count_up_next = count_up_reg;
    if (wr_cnt_lo) begin
      timer_count_next = {temp_byte_reg, bus_wdata_in}; // [RULE4] [RULE10] [RULE11]
    end else if (timer_tick) begin
      if (dual_slope) begin
        if (count_up_reg) begin
          if (timer_count_reg >= top_value) begin
            count_up_next = 1'b0;
            timer_count_next = timer_count_reg - 16'h0001; // [RULE8]
          end else begin
            timer_count_next = timer_count_reg + 16'h0001;
          end
        end else begin
          if (at_bottom) begin
            count_up_next = 1'b1;
            timer_count_next = timer_count_reg + 16'h0001;
          end else begin
            timer_count_next = timer_count_reg - 16'h0001; // [RULE8]
          end
        end
      end else if (at_top) begin
        timer_count_next = `TCX_MIN_COUNT; // [RULE8]
      end else begin
        timer_count_next = timer_count_reg + 16'h0001; // [RULE23]
      end
    end
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_count_reg <= `TCX_RST_COUNT;
      count_up_reg <= 1'b1;
    end else begin
      timer_count_reg <= timer_count_next;
      count_up_reg <= count_up_next;
    end
  end

  // Shared high-byte latch
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      temp_byte_reg <= 8'h00;
    end else if (wr_any_hi) begin
      temp_byte_reg <= bus_wdata_in; // [RULE2]
    end else if (rd_cnt_lo) begin
      temp_byte_reg <= timer_count_reg[15:8]; // [RULE3]
    end else if (rd_cap_lo) begin
      temp_byte_reg <= capture_value_reg[15:8]; // [RULE18]
    end
  end
  // Otherwise the latch keeps its byte for reuse by later writes [RULE6]

  // Capture register and compare registers
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      capture_value_reg <= `TCX_RST_WORD;
      compare_a_reg <= `TCX_RST_WORD;
      compare_b_reg <= `TCX_RST_WORD;
    end else begin
      if (capture_event) begin
        capture_value_reg <= timer_count_reg; // [RULE15]
      end else if (wr_cap_lo & capture_is_top) begin
        capture_value_reg <= {temp_byte_reg, bus_wdata_in}; // [RULE19]
      end
      if (bus_wr_in & (bus_addr_in == `TCX_ADDR_CMPA_LO)) begin
        compare_a_reg <= {temp_byte_reg, bus_wdata_in};
      end
      if (bus_wr_in & (bus_addr_in == `TCX_ADDR_CMPB_LO)) begin
        compare_b_reg <= {temp_byte_reg, bus_wdata_in};
      end
    end
  end

  // Control registers
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      control_reg_a_reg <= `TCX_RST_CTRL_A;
      control_reg_b_reg <= `TCX_RST_CTRL_B;
      mask_reg <= `TCX_RST_MASK;
    end else if (bus_wr_in) begin
      if (bus_addr_in == `TCX_ADDR_CTRL_A) begin
        control_reg_a_reg <= bus_wdata_in;
      end
      if (bus_addr_in == `TCX_ADDR_CTRL_B) begin
        control_reg_b_reg <= bus_wdata_in;
      end
      if (bus_addr_in == `TCX_ADDR_MASK) begin
        mask_reg <= bus_wdata_in;
      end
    end
  end

  // Event flags: a set in the clearing cycle wins
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      overflow_flag_reg <= 1'b0;
      capture_flag_reg <= 1'b0;
    end else begin
      if (overflow_event) begin
        overflow_flag_reg <= 1'b1; // [RULE13]
      end else if (overflow_irq_ack_in | (bus_wr_in & (bus_addr_in == `TCX_ADDR_FLAGS) &
                   bus_wdata_in[`TCX_FLAG_OVF])) begin
        overflow_flag_reg <= 1'b0;
      end
      if (capture_event) begin
        capture_flag_reg <= 1'b1; // [RULE15]
      end else if (capture_irq_ack_in) begin
        capture_flag_reg <= 1'b0; // [RULE16]
      end else if (bus_wr_in & (bus_addr_in == `TCX_ADDR_FLAGS) & bus_wdata_in[`TCX_FLAG_CAP]) begin
        capture_flag_reg <= 1'b0; // [RULE17]
      end
    end
  end

  // Interrupt requests
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      overflow_irq_reg <= 1'b0;
      capture_irq_reg <= 1'b0;
    end else begin
      overflow_irq_reg <= overflow_flag_reg & mask_reg[`TCX_FLAG_OVF] & ~overflow_irq_ack_in; // [RULE13]
      capture_irq_reg <= capture_flag_reg & mask_reg[`TCX_FLAG_CAP] & ~capture_irq_ack_in; // [RULE16]
    end
  end

  // Read data mux
  always @* begin
    rdata_next = 8'h00;
    if (bus_rd_in) begin
      case (bus_addr_in)
        `TCX_ADDR_CTRL_A: rdata_next = control_reg_a_reg;
        `TCX_ADDR_CTRL_B: rdata_next = control_reg_b_reg;
        `TCX_ADDR_FLAGS: begin
          rdata_next[`TCX_FLAG_OVF] = overflow_flag_reg;
          rdata_next[`TCX_FLAG_CAP] = capture_flag_reg;
        end
        `TCX_ADDR_MASK: rdata_next = mask_reg;
        `TCX_ADDR_CNT_LO: rdata_next = timer_count_reg[7:0]; // [RULE1]
        `TCX_ADDR_CNT_HI: rdata_next = temp_byte_reg; // [RULE2]
        `TCX_ADDR_CAP_LO: rdata_next = capture_value_reg[7:0];
        `TCX_ADDR_CAP_HI: rdata_next = temp_byte_reg; // [RULE18]
        `TCX_ADDR_CMPA_LO: rdata_next = compare_a_reg[7:0];
        `TCX_ADDR_CMPA_HI: rdata_next = compare_a_reg[15:8]; // [RULE22]
        `TCX_ADDR_CMPB_LO: rdata_next = compare_b_reg[7:0];
        `TCX_ADDR_CMPB_HI: rdata_next = compare_b_reg[15:8]; // [RULE22]
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata_out = rdata_reg;
  assign overflow_irq_out = overflow_irq_reg;
  assign capture_irq_out = capture_irq_reg;

endmodule

`default_nettype wire

// file: verification/tb.sv
// Self-checking testbench for the sixteen-bit timer
`default_nettype none
`include "tcx_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in, rst_in, ext_tick, cap_pin, cmp_out, ovf_ack, cap_ack, wr, rd, ovf_irq, cap_irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [15:0] x, v;
  int mismatches, cmp_count, i;
  int divs[4] = '{8, 64, 256, 1024};
  tcx_timer16 tcx_timer16_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_addr_in(addr), .bus_wdata_in(wdata),
    .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata), .ext_tick_in(ext_tick), .capture_pin_in(cap_pin),
    .comparator_output_in(cmp_out), .overflow_irq_ack_in(ovf_ack), .capture_irq_ack_in(cap_ack),
    .overflow_irq_out(ovf_irq), .capture_irq_out(cap_irq));
  tcx_cpu_model tcx_cpu_model_i (.sys_clk_in(sys_clk_in), .bus_rdata_in(rdata), .bus_addr_out(addr),
    .bus_wdata_out(wdata), .bus_wr_out(wr), .bus_rd_out(rd));
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [15:0] after_ticks(input logic [15:0] s, input int n);
    return s + 16'(n);
  endfunction
  task automatic w(input logic [3:0] a, input logic [7:0] d);
    tcx_cpu_model_i.xfer(1'b1, a, d);
  endtask
  task automatic r(input logic [3:0] a, input logic [7:0] e);
    tcx_cpu_model_i.xfer(1'b0, a, 8'h00);
    check("rdata", {8'h00, e}, {8'h00, tcx_cpu_model_i.last_rd});
  endtask
  task automatic r16(input logic [3:0] lo, input logic [15:0] e);
    tcx_cpu_model_i.rd16(lo, v);
    check("word", e, v);
  endtask
  task automatic gap(input int n);
    tcx_cpu_model_i.idle(n);
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #(20000 * 100);
    mismatches++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hc4ecca39));
    mismatches = 0;
    cmp_count = 0;
    {rst_in, ext_tick, cap_pin, cmp_out, ovf_ack, cap_ack} = 6'b100000;
    repeat (6) @(posedge sys_clk_in);
    #1 rst_in = 1'b0;
    for (i = 0; i < 8; i++) r(4'(i), 8'h00);
    for (i = 12; i < 16; i++) begin
      w(4'(i), 8'h5a);
      r(4'(i), 8'h00);
    end
    w(`TCX_ADDR_MASK, 8'h21);
    x = 16'($urandom);
    tcx_cpu_model_i.wr16(4'h4, x);
    r16(4'h4, x);
    gap(20);
    r16(4'h4, x);
    w(`TCX_ADDR_CTRL_B, 8'h01);
    x = 16'($urandom_range(16'hfffe));
    tcx_cpu_model_i.wr16(4'h4, x);
    w(`TCX_ADDR_CTRL_B, 8'h00);
    r16(4'h4, after_ticks(x, 1));
    x = 16'hfff8 + 16'($urandom_range(7));
    tcx_cpu_model_i.wr16(4'h4, x);
    w(`TCX_ADDR_CTRL_B, 8'h01);
    gap(9);
    w(`TCX_ADDR_CTRL_B, 8'h00);
    r16(4'h4, after_ticks(x, 10));
    r(`TCX_ADDR_FLAGS, 8'h01);
    check("ovf irq", 16'h0001, {15'h0, ovf_irq});
    ovf_ack = 1'b1;
    gap(1);
    ovf_ack = 1'b0;
    r(`TCX_ADDR_FLAGS, 8'h00);
    foreach (divs[j]) begin
      x = 16'($urandom_range(16'hff00));
      tcx_cpu_model_i.wr16(4'h4, x);
      w(`TCX_ADDR_CTRL_B, 8'(j + 2));
      gap(2 * divs[j] - 1);
      w(`TCX_ADDR_CTRL_B, 8'h00);
      r16(4'h4, after_ticks(x, 2));
    end
    for (i = 6; i < 8; i++) begin
      x = 16'($urandom_range(16'hff00));
      tcx_cpu_model_i.wr16(4'h4, x);
      w(`TCX_ADDR_CTRL_B, 8'(i));
      gap(1);
      repeat (5) begin
        ext_tick = 1'b1;
        gap(2);
        ext_tick = 1'b0;
        gap(2);
      end
      ext_tick = 1'b1;
      gap(2);
      w(`TCX_ADDR_CTRL_B, 8'h00);
      ext_tick = 1'b0;
      r16(4'h4, after_ticks(x, (i == 7) ? 6 : 5));
    end
    x = 16'($urandom);
    tcx_cpu_model_i.wr16(4'h4, x);
    w(`TCX_ADDR_CTRL_B, 8'h40);
    gap(1);
    cap_pin = 1'b1;
    gap(3);
    check("cap irq", 16'h0001, {15'h0, cap_irq});
    r(`TCX_ADDR_FLAGS, 8'h20);
    r16(4'h6, x);
    tcx_cpu_model_i.wr16(4'h4, ~x);
    gap(1);
    cap_pin = 1'b0;
    gap(3);
    r16(4'h6, x);
    cap_ack = 1'b1;
    gap(1);
    cap_ack = 1'b0;
    r(`TCX_ADDR_FLAGS, 8'h00);
    w(`TCX_ADDR_CTRL_A, 8'h04);
    tcx_cpu_model_i.wr16(4'h4, ~x);
    gap(1);
    cmp_out = 1'b1;
    gap(3);
    r16(4'h6, ~x);
    w(`TCX_ADDR_FLAGS, 8'h00);
    r(`TCX_ADDR_FLAGS, 8'h20);
    w(`TCX_ADDR_FLAGS, 8'h20);
    r(`TCX_ADDR_FLAGS, 8'h00);
    w(`TCX_ADDR_CTRL_A, 8'h00);
    w(`TCX_ADDR_CTRL_B, 8'h18);
    tcx_cpu_model_i.wr16(4'h6, x);
    r16(4'h6, x);
    w(`TCX_ADDR_CTRL_B, 8'h00);
    tcx_cpu_model_i.wr16(4'h6, ~x);
    r16(4'h6, x);
    x = 16'($urandom);
    w(4'h9, x[15:8]);
    w(4'h8, x[7:0]);
    w(4'h5, ~x[15:8]);
    r(4'h9, x[15:8]);
    w(4'h5, x[7:0]);
    w(4'h4, x[15:8]);
    w(4'h8, 8'h3c);
    r(4'h9, x[7:0]);
    w(4'h5, x[15:8]);
    r(4'h5, x[15:8]);
    // Dual slope with fixed top 0x00ff: turn at top, overflow at bottom
    w(`TCX_ADDR_CTRL_A, 8'h01);
    tcx_cpu_model_i.wr16(4'h4, 16'h00fd);
    w(`TCX_ADDR_CTRL_B, 8'h01);
    gap(4);
    w(`TCX_ADDR_CTRL_B, 8'h00);
    r16(4'h4, 16'h00fc);
    tcx_cpu_model_i.wr16(4'h4, 16'h0002);
    w(`TCX_ADDR_CTRL_B, 8'h01);
    gap(4);
    w(`TCX_ADDR_CTRL_B, 8'h00);
    r16(4'h4, 16'h0003);
    r(`TCX_ADDR_FLAGS, 8'h01);
    gap(2);
    stop_test();
  end
endmodule
bind tcx_timer16 tcx_timer16_sva tcx_timer16_sva_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
  .bus_rdata_out(bus_rdata_out), .ext_tick_in(ext_tick_in), .capture_pin_in(capture_pin_in),
  .comparator_output_in(comparator_output_in), .overflow_irq_ack_in(overflow_irq_ack_in),
  .capture_irq_ack_in(capture_irq_ack_in), .overflow_irq_out(overflow_irq_out), .capture_irq_out(capture_irq_out));
`default_nettype wire

// file: verification/tcx_cpu_model.sv
// Processor core model on the timer's byte-wide register port
`default_nettype none
module tcx_cpu_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] bus_rdata_in,
  output logic [3:0] bus_addr_out,
  output logic [7:0] bus_wdata_out,
  output logic bus_wr_out,
  output logic bus_rd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_rd;
  initial begin
    bus_addr_out = 4'h0;
    bus_wdata_out = 8'h00;
    bus_wr_out = 1'b0;
    bus_rd_out = 1'b0;
  end
  // One access per edge, read data taken just after it
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    bus_wr_out = w;
    bus_rd_out = ~w;
    bus_addr_out = a;
    bus_wdata_out = d;
    @(posedge sys_clk_in);
    #1;
    last_rd = bus_rdata_in;
  endtask
  // Bus released, data lines inverted
  task automatic idle(input int n);
    bus_wr_out = 1'b0;
    bus_rd_out = 1'b0;
    bus_wdata_out = ~bus_wdata_out;
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // Pairs run unbroken, as with interrupts blocked
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    xfer(1'b1, lo + 4'h1, v[15:8]);
    xfer(1'b1, lo, v[7:0]);
  endtask
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    xfer(1'b0, lo, 8'h00);
    v[7:0] = last_rd;
    xfer(1'b0, lo + 4'h1, 8'h00);
    v[15:8] = last_rd;
  endtask
endmodule
`default_nettype wire

// file: verification/tcx_timer16_sva.sv
// Assertions on the timer's register port and interrupts
`default_nettype none
module tcx_timer16_sva (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [7:0] bus_rdata_out,
  input wire logic ext_tick_in,
  input wire logic capture_pin_in,
  input wire logic comparator_output_in,
  input wire logic overflow_irq_ack_in,
  input wire logic capture_irq_ack_in,
  input wire logic overflow_irq_out,
  input wire logic capture_irq_out
);
  logic [2:0] cs_reg;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cs_reg <= 3'h0;
    end else if (bus_wr_in && bus_addr_in == 4'h1) begin
      cs_reg <= bus_wdata_in[2:0];
    end
  end
  rd_idle_a: assert property (!$past(bus_rd_in) |-> bus_rdata_out == 8'h00)
    else $error("read data not zero while idle");
  unmapped_rd_a: assert property ($past(bus_rd_in) && $past(bus_addr_in) >= 4'hc |-> bus_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  latch_rd_a: assert property (bus_wr_in && bus_addr_in == 4'h5 ##1 bus_rd_in && bus_addr_in == 4'h5
    |=> bus_rdata_out == $past(bus_wdata_in, 2)) else $error("upper count location not the latch");
  cmp_bypass_a: assert property (bus_wr_in && bus_addr_in == 4'h9 ##1 bus_wr_in && bus_addr_in == 4'h8
    ##1 bus_wr_in && bus_addr_in == 4'h5 ##1 bus_rd_in && bus_addr_in == 4'h9
    |=> bus_rdata_out == $past(bus_wdata_in, 4)) else $error("compare upper read used latch");
  latch_reuse_a: assert property (bus_wr_in && bus_addr_in == 4'h5 ##1 bus_wr_in && bus_addr_in == 4'h4
    ##1 bus_wr_in && bus_addr_in == 4'h8 ##1 bus_rd_in && bus_addr_in == 4'h9
    |=> bus_rdata_out == $past(bus_wdata_in, 4)) else $error("latch not kept for reuse");
  cnt_atomic_a: assert property (cs_reg == 3'h0 && bus_wr_in && bus_addr_in == 4'h5
    ##1 bus_wr_in && bus_addr_in == 4'h4 ##1 bus_rd_in && bus_addr_in == 4'h4 ##1 bus_rd_in && bus_addr_in == 4'h5
    |-> bus_rdata_out == $past(bus_wdata_in, 2) ##1 bus_rdata_out == $past(bus_wdata_in, 4))
    else $error("halted count write and read differ");
  ovf_ack_a: assert property (overflow_irq_ack_in |-> ##2 !overflow_irq_out)
    else $error("overflow request kept after service");
  cap_ack_a: assert property (capture_irq_ack_in && $stable(capture_pin_in) && $stable(comparator_output_in)
    |-> ##2 !capture_irq_out) else $error("capture request kept after service");
  cap_w1c_a: assert property (bus_wr_in && bus_addr_in == 4'h2 && bus_wdata_in[5] && $stable(capture_pin_in)
    && $stable(comparator_output_in) |-> ##2 !capture_irq_out) else $error("capture flag not cleared by one");
  cap_rise_a: assert property ($rose(capture_irq_out) |-> $past(capture_pin_in, 2) != $past(capture_pin_in, 3)
    || $past(comparator_output_in, 2) != $past(comparator_output_in, 3)) else $error("capture without input change");
endmodule
`default_nettype wire
